// >>> core/logic_ops_unit.sv
// Purpose: execute unsigned compares in register and immediate forms, AND in three operand forms, OR in immediate and memory forms
// Assumes: sequencer presents one instruction word per accept, memory data later
// Notes: register and immediate forms finish in one edge, memory forms stall
`timescale 1ns/1ps
`default_nettype none

module logic_ops_unit (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // instruction from the sequencer
  input wire logic instr_valid_i,
  input wire logic [23:0] instr_i,
  // memory operand path
  input wire logic mem_valid_i,
  input wire logic [23:0] mem_data_i,
  // register preload from the sequencer
  input wire logic load_valid_i,
  input wire logic [5:0] load_sel_i,
  input wire logic [23:0] load_data_i,
  // state and answers
  output logic_ops_pkg::reg_file_t regs_o,
  output logic_ops_pkg::cond_t cond_o,
  output logic busy_o,
  output logic mem_wait_o,
  output logic done_o,
  output logic illegal_o
);

  // one-hot code to slot index
  function automatic logic [2:0] sel_index(input logic [5:0] code);
    logic [2:0] idx;
    idx = 3'h0;
    for (int n = 0; n < logic_ops_pkg::NUM_REGS; n++) begin
      if (code[n]) begin
        idx = 3'(n);
      end
    end
    return idx;
  endfunction

  // true for exactly one bit set
  function automatic logic sel_legal(input logic [5:0] code);
    return (code != 6'h00) && ((code & (code - 6'h01)) == 6'h00);
  endfunction

  // sign and zero status of a word
  function automatic logic_ops_pkg::cond_t status_of(input logic [23:0] w);
    logic_ops_pkg::cond_t c;
    c.zero = (w == 24'h000000);
    c.neg = w[23];
    c.pos = !w[23] && (w != 24'h000000);
    return c;
  endfunction

  // unsigned second minus first
  function automatic logic_ops_pkg::cond_t ucompare(input logic [23:0] r2, input logic [23:0] r1);
    logic_ops_pkg::cond_t c;
    c.zero = (r2 == r1);
    c.pos = (r2 > r1);
    c.neg = (r2 < r1);
    return c;
  endfunction

  logic_ops_pkg::reg_file_t regs, next_regs;
  logic_ops_pkg::cond_t cond, next_cond;
  logic_ops_pkg::exec_state_t state, next_state;
  logic busy, next_busy;
  logic mem_or, next_mem_or;
  logic done, next_done;
  logic illegal, next_illegal;
  logic_ops_pkg::op_kind_t kind;
  logic [5:0] r1_code, r2_code;
  logic [2:0] r1_idx, r2_idx;
  logic [7:0] imm;
  logic pair_ok;
  logic take;

  // instruction field decode
  always_comb begin
    r1_code = instr_i[logic_ops_pkg::R1_MSB:logic_ops_pkg::R1_LSB];
    r2_code = instr_i[logic_ops_pkg::R2_MSB:logic_ops_pkg::R2_LSB];
    imm = instr_i[logic_ops_pkg::IMM_MSB:0];
    r1_idx = sel_index(r1_code);
    r2_idx = sel_index(r2_code);
    pair_ok = sel_legal(r1_code) && sel_legal(r2_code);
    take = (state == logic_ops_pkg::ST_IDLE) && instr_valid_i;
    kind = logic_ops_pkg::K_NONE;
    if (instr_i[logic_ops_pkg::MEM_OP_MSB:logic_ops_pkg::MEM_OP_LSB] == logic_ops_pkg::OP_AND_MEM) begin
      kind = logic_ops_pkg::K_AND_MEM;
    end else if (instr_i[logic_ops_pkg::MEM_OP_MSB:logic_ops_pkg::MEM_OP_LSB] == logic_ops_pkg::OP_OR_MEM) begin
      kind = logic_ops_pkg::K_OR_MEM;
    end else begin
      case (instr_i[logic_ops_pkg::AUG_MSB:logic_ops_pkg::AUG_LSB])
        logic_ops_pkg::OP_CMP_PAIR: kind = logic_ops_pkg::K_CMP_PAIR;
        logic_ops_pkg::OP_AND_PAIR: kind = logic_ops_pkg::K_AND_PAIR;
        logic_ops_pkg::OP_CMP_BYTE: kind = logic_ops_pkg::K_CMP_BYTE;
        logic_ops_pkg::OP_AND_BYTE: kind = logic_ops_pkg::K_AND_BYTE;
        logic_ops_pkg::OP_OR_BYTE: kind = logic_ops_pkg::K_OR_BYTE;
        default: kind = logic_ops_pkg::K_NONE;
      endcase
    end
  end

  // next register, condition and sequencing values
  always_comb begin
    next_regs = regs;
    next_cond = cond;
    next_state = state;
    next_busy = busy;
    next_mem_or = mem_or;
    next_done = 1'b0;
    next_illegal = 1'b0;
    case (state)
      logic_ops_pkg::ST_IDLE: begin
        if (instr_valid_i) begin
          next_done = 1'b1;
          case (kind)
            logic_ops_pkg::K_CMP_PAIR: begin
              if (!pair_ok) begin
                next_illegal = 1'b1;
              end else begin
                next_cond = ucompare(regs[r2_idx], regs[r1_idx]);
              end
            end
            logic_ops_pkg::K_AND_PAIR: begin
              if (!pair_ok) begin
                next_illegal = 1'b1;
              end else begin
                next_regs[r2_idx] = regs[r1_idx] & regs[r2_idx];
                next_cond = status_of(regs[r1_idx] & regs[r2_idx]);
              end
            end
            logic_ops_pkg::K_CMP_BYTE: begin
              next_cond = ucompare({16'h0000, regs[logic_ops_pkg::IDX_A][7:0]}, {16'h0000, imm});
            end
            logic_ops_pkg::K_AND_BYTE: begin
              next_regs[logic_ops_pkg::IDX_A][7:0] = regs[logic_ops_pkg::IDX_A][7:0] & imm;
              next_cond = status_of({regs[logic_ops_pkg::IDX_A][23:8], regs[logic_ops_pkg::IDX_A][7:0] & imm});
            end
            logic_ops_pkg::K_OR_BYTE: begin
              next_regs[logic_ops_pkg::IDX_A][7:0] = regs[logic_ops_pkg::IDX_A][7:0] | imm;
              next_cond = status_of({regs[logic_ops_pkg::IDX_A][23:8], regs[logic_ops_pkg::IDX_A][7:0] | imm});
            end
            logic_ops_pkg::K_AND_MEM, logic_ops_pkg::K_OR_MEM: begin
              next_done = 1'b0;
              next_state = logic_ops_pkg::ST_MEM_WAIT;
              next_busy = 1'b1;
              next_mem_or = (kind == logic_ops_pkg::K_OR_MEM);
            end
            default: begin
              next_illegal = 1'b1;
            end
          endcase
        end else if (load_valid_i && sel_legal(load_sel_i)) begin
          next_regs[sel_index(load_sel_i)] = load_data_i;
        end
      end
      logic_ops_pkg::ST_MEM_WAIT: begin
        if (mem_valid_i) begin
          next_state = logic_ops_pkg::ST_IDLE;
          next_busy = 1'b0;
          next_done = 1'b1;
          if (mem_or) begin
            next_regs[logic_ops_pkg::IDX_A] = regs[logic_ops_pkg::IDX_A] | mem_data_i;
            next_cond = status_of(regs[logic_ops_pkg::IDX_A] | mem_data_i);
          end else begin
            next_regs[logic_ops_pkg::IDX_A] = regs[logic_ops_pkg::IDX_A] & mem_data_i;
            next_cond = status_of(regs[logic_ops_pkg::IDX_A] & mem_data_i);
          end
        end
      end
      default: begin
        next_state = logic_ops_pkg::ST_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int n = 0; n < logic_ops_pkg::NUM_REGS; n++) begin
        regs[n] <= logic_ops_pkg::REG_RESET;
      end
      cond <= logic_ops_pkg::COND_RESET;
      state <= logic_ops_pkg::ST_IDLE;
      busy <= 1'b0;
      mem_or <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      regs <= next_regs;
      cond <= next_cond;
      state <= next_state;
      busy <= next_busy;
      mem_or <= next_mem_or;
      done <= next_done;
      illegal <= next_illegal;
    end
  end

  // outputs straight from the flops
  assign regs_o = regs;
  assign cond_o = cond;
  assign busy_o = busy;
  assign mem_wait_o = busy;
  assign done_o = done;
  assign illegal_o = illegal;

  // checks
  sequence mem_issue_s;
    take && (kind == logic_ops_pkg::K_AND_MEM || kind == logic_ops_pkg::K_OR_MEM);
  endsequence

  sequence mem_arrive_s;
    busy && mem_valid_i;
  endsequence

  AST_CMP_PAIR_KEEPS_REGS: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_CMP_PAIR |=> regs == $past(regs) && done)
    else $error("pair compare altered a register");

  AST_CMP_PAIR_ORDER: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_CMP_PAIR && pair_ok && regs[r2_idx] > regs[r1_idx]
    |=> cond == 3'h4)
    else $error("greater R2 did not give positive");

  AST_CMP_UNSIGNED: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_CMP_PAIR && pair_ok && regs[r2_idx][23] && !regs[r1_idx][23]
    |=> cond.pos && !cond.neg)
    else $error("compare treated operands as signed");

  AST_AND_PAIR_DEST: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_AND_PAIR && pair_ok
    |=> regs[$past(r2_idx)] == ($past(regs[r1_idx]) & $past(regs[r2_idx])))
    else $error("pair AND result wrong or misplaced");

  AST_R1_KEPT: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_AND_PAIR && pair_ok && r1_idx != r2_idx
    |=> regs[$past(r1_idx)] == $past(regs[r1_idx]))
    else $error("first register was modified");

  AST_SEL_DECODE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_AND_PAIR && r2_code == 6'h08 && r1_code == 6'h10
    |=> regs[logic_ops_pkg::IDX_E] == ($past(regs[logic_ops_pkg::IDX_A]) & $past(regs[logic_ops_pkg::IDX_E])))
    else $error("code 10 did not select register E");

  AST_CMP_BYTE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_CMP_BYTE
    |=> regs == $past(regs) && cond.zero == ($past(regs[logic_ops_pkg::IDX_A][7:0]) == $past(imm)))
    else $error("byte compare wrong");

  AST_AND_BYTE_UPPER: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_AND_BYTE
    |=> regs[logic_ops_pkg::IDX_A][23:8] == $past(regs[logic_ops_pkg::IDX_A][23:8])
    && regs[logic_ops_pkg::IDX_A][7:0] == ($past(regs[logic_ops_pkg::IDX_A][7:0]) & $past(imm)))
    else $error("byte AND disturbed upper bits");

  AST_OR_BYTE_UPPER: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_OR_BYTE
    |=> regs[logic_ops_pkg::IDX_A][23:8] == $past(regs[logic_ops_pkg::IDX_A][23:8])
    && regs[logic_ops_pkg::IDX_A][7:0] == ($past(regs[logic_ops_pkg::IDX_A][7:0]) | $past(imm)))
    else $error("byte OR disturbed upper bits");

  AST_COND_STATUS: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_OR_BYTE |=> cond == status_of(regs[logic_ops_pkg::IDX_A]))
    else $error("condition does not match result");

  AST_ILLEGAL_SEL: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    take && kind == logic_ops_pkg::K_AND_PAIR && !pair_ok |=> illegal && regs == $past(regs))
    else $error("illegal select changed a register");

  AST_MEM_STALL: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    mem_issue_s ##1 (busy && !mem_valid_i) |=> regs == $past(regs) && busy && !done)
    else $error("memory form acted before data");

  AST_MEM_AND: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    mem_arrive_s and !mem_or |=> done && !busy
    && regs[logic_ops_pkg::IDX_A] == ($past(regs[logic_ops_pkg::IDX_A]) & $past(mem_data_i)))
    else $error("memory AND result wrong");

  AST_MEM_OR: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    mem_arrive_s and mem_or |=> done && !busy
    && regs[logic_ops_pkg::IDX_A] == ($past(regs[logic_ops_pkg::IDX_A]) | $past(mem_data_i)))
    else $error("memory OR result wrong");

endmodule // logic_ops_unit

`default_nettype wire

// >>> core/logic_ops_pkg.sv
// Purpose: constants and types for the unsigned compare and AND/OR datapath
// Assumes: 24-bit words, six working registers addressed by one-hot octal codes
// Notes: opcode values are the octal codes written out in hexadecimal
package logic_ops_pkg;

  // word and field layout of an instruction
  localparam int WORD_W = 24;
  localparam int AUG_MSB = 23;
  localparam int AUG_LSB = 12;
  localparam int MEM_OP_MSB = 23;
  localparam int MEM_OP_LSB = 18;
  localparam int R1_MSB = 11;
  localparam int R1_LSB = 6;
  localparam int R2_MSB = 5;
  localparam int R2_LSB = 0;
  localparam int IMM_MSB = 7;
  localparam int NUM_REGS = 6;

  // augmented operation fields (octal 0025, 0026, 0015, 0016, 0004)
  localparam logic [11:0] OP_CMP_PAIR = 12'h015;
  localparam logic [11:0] OP_AND_PAIR = 12'h016;
  localparam logic [11:0] OP_CMP_BYTE = 12'h00D;
  localparam logic [11:0] OP_AND_BYTE = 12'h00E;
  localparam logic [11:0] OP_OR_BYTE = 12'h004;
  // memory opcodes (octal 36 and 35)
  localparam logic [5:0] OP_AND_MEM = 6'h1E;
  localparam logic [5:0] OP_OR_MEM = 6'h1D;

  // register slots; slot n answers to one-hot code with bit n set
  localparam logic [2:0] IDX_I = 3'h0;
  localparam logic [2:0] IDX_J = 3'h1;
  localparam logic [2:0] IDX_K = 3'h2;
  localparam logic [2:0] IDX_E = 3'h3;
  localparam logic [2:0] IDX_A = 3'h4;
  localparam logic [2:0] IDX_T = 3'h5;

  // values after reset
  localparam logic [23:0] REG_RESET = 24'h000000;

  typedef logic [5:0][23:0] reg_file_t;

  typedef struct packed {
    logic pos;
    logic neg;
    logic zero;
  } cond_t;

  localparam cond_t COND_RESET = 3'h0;

  typedef enum logic [2:0] {
    K_NONE, K_CMP_PAIR, K_AND_PAIR, K_CMP_BYTE, K_AND_BYTE, K_OR_BYTE, K_AND_MEM, K_OR_MEM
  } op_kind_t;

  typedef enum logic {
    ST_IDLE, ST_MEM_WAIT
  } exec_state_t;

endpackage

// >>> verification/mem_responder.sv
// Purpose: memory operand responder beside the datapath
// Assumes: an operand is wanted while mem_wait_i is high
// Notes: the data bus shows the inverted last word when not valid
`timescale 1ns/1ps
`default_nettype none

module mem_responder (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // control from the bench
  input wire logic mem_wait_i,
  input wire logic [3:0] delay_i,
  input wire logic [23:0] word_i,
  // operand path
  output logic mem_valid_o,
  output logic [23:0] mem_data_o
);
  logic [3:0] count;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= 4'h0;
      mem_valid_o <= 1'b0;
      mem_data_o <= 24'hA5A5A5;
    end else if (mem_valid_o) begin
      mem_valid_o <= 1'b0;
      mem_data_o <= ~mem_data_o; // released bus, no stale word
      count <= 4'h0;
    end else if (mem_wait_i && count == delay_i) begin
      mem_valid_o <= 1'b1;
      mem_data_o <= word_i;
    end else if (mem_wait_i) begin
      count <= count + 4'h1;
    end
  end
endmodule // mem_responder

`default_nettype wire

// >>> verification/logical_compare_and_bitwise_ops_tb.sv
// Purpose: self-checking bench for the compare and AND/OR datapath
// Assumes: expected state kept in a bench model, results in a queue
// Notes: inputs change at the falling edge, outputs read 1 ns after rising
`timescale 1ns/1ps
`default_nettype none

module logical_compare_and_bitwise_ops_tb;
  typedef struct packed {
    logic_ops_pkg::reg_file_t r;
    logic_ops_pkg::cond_t c;
    logic ill;
  } exp_t;
  logic clock_i, reset_n_i, instr_valid_i, mem_valid_i, load_valid_i;
  logic busy_o, mem_wait_o, done_o, illegal_o;
  logic [23:0] instr_i, mem_data_i, load_data_i, word, v;
  logic [5:0] load_sel_i;
  logic [3:0] delay;
  logic [31:0] lfsr;
  logic_ops_pkg::reg_file_t regs_o, m_regs;
  logic_ops_pkg::cond_t cond_o, m_cond;
  exp_t q[$];
  exp_t got_e;
  int num_errors, compares;

  logic_ops_unit u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i), .load_valid_i(load_valid_i),
    .load_sel_i(load_sel_i), .load_data_i(load_data_i), .regs_o(regs_o), .cond_o(cond_o),
    .busy_o(busy_o), .mem_wait_o(mem_wait_o), .done_o(done_o), .illegal_o(illegal_o));
  mem_responder u_mem (.clock_i(clock_i), .reset_n_i(reset_n_i), .mem_wait_i(mem_wait_o), .delay_i(delay),
    .word_i(word), .mem_valid_o(mem_valid_i), .mem_data_o(mem_data_i));

  // clock, 40 ns period
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  function automatic logic [23:0] rnd();
    repeat (7) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[23:0];
  endfunction

  function automatic logic_ops_pkg::cond_t sgn(input logic [23:0] x);
    return (x == 24'h0) ? 3'h1 : (x[23] ? 3'h2 : 3'h4);
  endfunction

  // unsigned, second operand minus first
  function automatic logic_ops_pkg::cond_t ucmp(input logic [23:0] a, input logic [23:0] b);
    return (b > a) ? 3'h4 : ((b < a) ? 3'h2 : 3'h1);
  endfunction

  function automatic int sidx(input logic [5:0] c);
    for (int i = 0; i < 6; i++) if (c == (6'h1 << i)) return i;
    return -1;
  endfunction

  // compute expected result, then present the instruction
  task automatic issue(input logic [23:0] ins, input logic hold);
    exp_t e;
    int r1;
    int r2;
    int k;
    logic upd_a;
    logic is_mem;
    logic [23:0] a;
    e = '{m_regs, m_cond, 1'b0};
    r1 = sidx(ins[11:6]);
    r2 = sidx(ins[5:0]);
    a = m_regs[logic_ops_pkg::IDX_A];
    upd_a = 1'b1;
    is_mem = (ins[23:18] == logic_ops_pkg::OP_AND_MEM) || (ins[23:18] == logic_ops_pkg::OP_OR_MEM);
    case (ins[23:12])
      logic_ops_pkg::OP_CMP_PAIR, logic_ops_pkg::OP_AND_PAIR: begin
        upd_a = 1'b0;
        if (r1 < 0 || r2 < 0) e.ill = 1'b1;
        else if (ins[23:12] == logic_ops_pkg::OP_CMP_PAIR) e.c = ucmp(m_regs[r1], m_regs[r2]);
        else begin
          e.r[r2] = m_regs[r1] & m_regs[r2];
          e.c = sgn(e.r[r2]);
        end
      end
      logic_ops_pkg::OP_CMP_BYTE: begin
        upd_a = 1'b0;
        e.c = ucmp({16'h0, ins[7:0]}, {16'h0, a[7:0]});
      end
      logic_ops_pkg::OP_AND_BYTE: e.r[logic_ops_pkg::IDX_A] = {a[23:8], a[7:0] & ins[7:0]};
      logic_ops_pkg::OP_OR_BYTE: e.r[logic_ops_pkg::IDX_A] = {a[23:8], a[7:0] | ins[7:0]};
      default: begin
        if (ins[23:18] == logic_ops_pkg::OP_AND_MEM) e.r[logic_ops_pkg::IDX_A] = a & word;
        else if (ins[23:18] == logic_ops_pkg::OP_OR_MEM) e.r[logic_ops_pkg::IDX_A] = a | word;
        else e.ill = 1'b1;
      end
    endcase
    if (upd_a && !e.ill) e.c = sgn(e.r[logic_ops_pkg::IDX_A]);
    m_regs = e.r;
    m_cond = e.c;
    q.push_back(e);
    @(negedge clock_i);
    load_valid_i = 1'b0;
    instr_valid_i = 1'b1;
    instr_i = ins;
    if (is_mem) begin
      @(negedge clock_i);
      cmp_flag(mem_wait_o, 1'b1);
      instr_valid_i = hold; // held request while busy must be ignored
      for (k = 0; k < 40 && busy_o === 1'b1; k++) @(negedge clock_i);
      instr_valid_i = 1'b0;
      if (k == 40) num_errors++;
    end
  endtask

  task automatic load(input logic [5:0] sel, input logic [23:0] d);
    int i;
    i = sidx(sel);
    if (i >= 0) m_regs[i] = d;
    @(negedge clock_i);
    instr_valid_i = 1'b0;
    load_valid_i = 1'b1;
    load_sel_i = sel;
    load_data_i = d;
  endtask

  task automatic cmp_regs(input logic_ops_pkg::reg_file_t got, input logic_ops_pkg::reg_file_t want);
    compares++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected regs at %0t: got 0x%h want 0x%h", $time, got, want);
    end
  endtask

  task automatic cmp_cond(input logic_ops_pkg::cond_t got, input logic_ops_pkg::cond_t want);
    compares++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected cond at %0t: got 0x%h want 0x%h", $time, got, want);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic want);
    compares++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected flag at %0t: got 0x%h want 0x%h", $time, got, want);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d errors %0d left %0d", compares, num_errors, q.size());
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // take the oldest note on every completion
  always @(posedge clock_i) begin
    #1;
    if (done_o === 1'b1 && q.size() == 0) begin
      num_errors++;
      $display("unexpected done at %0t: got 0x1 want 0x0", $time);
    end else if (done_o === 1'b1) begin
      got_e = q.pop_front();
      cmp_regs(regs_o, got_e.r);
      cmp_cond(cond_o, got_e.c);
      cmp_flag(illegal_o, got_e.ill);
      cmp_flag(busy_o, 1'b0);
      cmp_flag(mem_wait_o, 1'b0);
    end
  end

  // hang guard
  initial begin
    repeat (30000) @(posedge clock_i);
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    {reset_n_i, instr_valid_i, load_valid_i, instr_i, load_sel_i, load_data_i} = '0;
    {word, delay, num_errors, compares} = '0;
    lfsr = 32'h27A2BEAD;
    m_regs = '0;
    m_cond = '0;
    repeat (10) @(negedge clock_i);
    reset_n_i = 1'b1;
    for (int i = 0; i < 6; i++) load(6'h1 << i, rnd());
    load(6'h03, rnd());
    load(6'h01, 24'h800000);
    load(6'h02, 24'h000001);
    issue({logic_ops_pkg::OP_CMP_PAIR, 6'h01, 6'h02}, 1'b0);
    for (int a = 0; a < 6; a++)
      for (int b = 0; b < 6; b++) issue({logic_ops_pkg::OP_CMP_PAIR, 6'h1 << a, 6'h1 << b}, 1'b0);
    for (int a = 0; a < 6; a++) begin
      for (int i = 0; i < 6; i++) load(6'h1 << i, rnd());
      for (int b = 0; b < 6; b++) issue({logic_ops_pkg::OP_AND_PAIR, 6'h1 << a, 6'h1 << b}, 1'b0);
    end
    load(6'h10, 24'hFFFF01);
    issue({logic_ops_pkg::OP_CMP_BYTE, 4'h0, 8'hFF}, 1'b0);
    issue({logic_ops_pkg::OP_CMP_BYTE, 4'h0, 8'h01}, 1'b0);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      issue({logic_ops_pkg::OP_CMP_BYTE, 4'h0, v[7:0]}, 1'b0);
      issue({logic_ops_pkg::OP_AND_BYTE, 4'h0, v[15:8]}, 1'b0);
      issue({logic_ops_pkg::OP_OR_BYTE, 4'h0, v[23:16]}, 1'b0);
      load(6'h10, rnd());
    end
    issue({logic_ops_pkg::OP_AND_PAIR, 6'h03, 6'h02}, 1'b0);
    issue({logic_ops_pkg::OP_CMP_PAIR, 6'h01, 6'h00}, 1'b0);
    issue(24'h0FF000, 1'b0);
    for (int i = 0; i < 4; i++) begin
      word = rnd();
      delay = 4'(i * 3);
      v = rnd();
      issue({i[0] ? logic_ops_pkg::OP_OR_MEM : logic_ops_pkg::OP_AND_MEM, v[17:0]}, i[1]);
    end
    @(negedge clock_i);
    instr_valid_i = 1'b0;
    repeat (4) @(negedge clock_i);
    if (q.size() != 0) num_errors++;
    wrap_up();
  end
endmodule // logical_compare_and_bitwise_ops_tb

`default_nettype wire
